// >>> verilog/cvb_map.svh
// register map, field positions, reset values and timing constants of the vendor bank
// Function
// - bypass bit shortens jack debounce to test value
// - mic handling delay 2 to 256 frames
// - stable time 0.1ms to 1024ms, saturating
// - long detect 2s to 128s, code 7 never
// - bias delay table 0.1ms to 4s
// - deepest sleep overrides; also pins, amps off
// - lighter sleep: link interface off, no responses
// - sleep exits only on POR or link-reset release
// - beep status live, cleared by resets
// - beep gain -48dB plus 6dB per code
// - quantize only when both beep enables set
// - beep counter delay 64ms to 512ms
// - beep path off, on, or during link reset
// - force bit powers speaker off at zero volume
// - two trip ramp, or single trip cut
// - step wait 2ms doubling, polling capped 16ms
// - low trip 110C plus 15C per code
// - status word: trips, forced flags, volumes
// - pump divisor 30..44 or 30..16 by code
// - pump clock source select
// - short detectors gated by enables, flags readable
// - verb 7FF payload 00 responds then resets
`ifndef CVB_MAP_SVH
`define CVB_MAP_SVH
`define CVB_SET       4'h7
`define CVB_GET       4'hf
`define CVB_V_STAT    8'hf7
`define CVB_V_RST     8'hff
`define CVB_FRST_KEY  8'h00
`define CVB_MSK_JACK  32'h0000_ff77
`define CVB_MSK_SLP   32'h0000_0003
`define CVB_MSK_PORT  32'h0000_000f
`define CVB_MSK_BEEP  32'h0000_1f3f
`define CVB_MSK_BTL   32'h003f_0ffc
`define CVB_MSK_CAP   32'h78ff_effd
`define CVB_DEF_JACK  32'h0000_3653
`define CVB_DEF_BEEP  32'h0000_0f32
`define CVB_DEF_BTL   32'h0002_0640
`define CVB_DEF_CAP   32'h4050_0880
`define CVB_B_BYP     15
`define CVB_B_DEEP    1
`define CVB_B_LIGHT   0
`define CVB_B_BSTAT   13
`define CVB_B_QEN     9
`define CVB_B_DEN     8
`define CVB_B_FORCE   17
`define CVB_B_SINGLE  16
`define CVB_B_RSEN    19
`define CVB_B_PSEN    16
`define CVB_B_RFLAG   25
`define CVB_B_PFLAG   24
`define CVB_B_PSEL    4
`define CVB_I_LRST    0
`define CVB_I_BEEP    1
`define CVB_I_HI      2
`define CVB_I_LO      3
`define CVB_I_RSC     4
`define CVB_I_PSC     5
`define CVB_CLK_KHZ   50000
`define CVB_TICK_MS   1
`define CVB_MS_CYC    (`CVB_TICK_MS * `CVB_CLK_KHZ)
`define CVB_TEST_DLY  14'd1
`define CVB_STAB_MAX  14'd10240
`define CVB_GMIN      7'd48
`define CVB_GSTEP     7'd6
`define CVB_TRIP_MIN  8'd110
`define CVB_TRIP_STEP 8'd15
`define CVB_DIV_MID   6'd30
`define CVB_POLL_MAX  17'd16
`endif

// >>> verilog/cvb_pkg.sv
// types of the vendor control bank
`default_nettype none
package cvb_pkg;
  typedef enum logic [1:0] {
    CVB_RUN   = 2'b00,
    CVB_LIGHT = 2'b01,
    CVB_DEEP  = 2'b10
  } cvb_sleep_t;
  typedef struct packed {
    logic [5:0][31:0] regs;
    logic [5:0]       s1;
    logic [5:0]       s2;
    logic [5:0]       s3;
    logic [5:0]       flt;
    cvb_sleep_t       sleep;
    logic             frst_pend;
    logic             beep_stat;
    logic [15:0]      tick;
    logic [16:0]      ms;
    logic [7:0]       vol;
    logic             mute;
    logic             off;
    logic             resp_valid;
    logic [31:0]      resp_data;
    logic             link_off;
    logic             pins_off;
    logic [3:0]       port_off;
    logic [13:0]      stable;
    logic [8:0]       mic_frames;
    logic [7:0]       long_s;
    logic [15:0]      bias;
    logic [6:0]       beep_gain;
    logic [9:0]       beep_ms;
    logic             beep_quant;
    logic             beep_on;
    logic [16:0]      wait_ms;
    logic [4:0]       poll_ms;
    logic [7:0]       low_trip;
    logic [5:0]       pump_div;
    logic             pump_sel;
    logic             reg_sense;
    logic             pump_sense;
  } cvb_state_t;
endpackage
`default_nettype wire

// >>> verilog/cvb_bank.sv
// vendor control and status bank of the audio function group
`timescale 1ns/1ps
`default_nettype none
`include "cvb_map.svh"
module cvb_bank
  import cvb_pkg::*;
#(
  parameter int unsigned MS_CYCLES = `CVB_MS_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        link_rst_n_i,
  input  wire logic        verb_valid_i,
  input  wire logic [11:0] verb_id_i,
  input  wire logic [7:0]  verb_payload_i,
  input  wire logic        d3cold_i,
  input  wire logic        beep_present_i,
  input  wire logic        temp_high_i,
  input  wire logic        temp_low_i,
  input  wire logic        reg_short_i,
  input  wire logic        pump_short_i,
  output logic             resp_valid_o,
  output logic [31:0]      resp_data_o,
  output logic             link_if_off_o,
  output logic             pins_amps_off_o,
  output logic [3:0]       port_off_o,
  output logic [13:0]      jack_stable_o,
  output logic [8:0]       mic_frames_o,
  output logic [7:0]       long_detect_o,
  output logic [15:0]      bias_delay_o,
  output logic [6:0]       beep_gain_o,
  output logic [9:0]       beep_delay_o,
  output logic             beep_quant_o,
  output logic             beep_path_on_o,
  output logic [16:0]      step_wait_o,
  output logic [4:0]       poll_ms_o,
  output logic [7:0]       low_trip_o,
  output logic [7:0]       spk_vol_o,
  output logic             spk_mute_o,
  output logic             spk_off_o,
  output logic [5:0]       pump_div_o,
  output logic             pump_sel_o,
  output logic             reg_sense_en_o,
  output logic             pump_sense_en_o
);

  cvb_state_t st;
  cvb_state_t next_st;
  logic [5:0] raw;
  logic [5:0] vd;
  logic [31:0] nv;
  logic [31:0] m;
  logic [31:0] stat;
  logic lrst_rise;
  logic ms_tick;
  logic step;
  logic hi;
  logic lo;

  // verb low byte to {hit, register index, byte lane}
  function automatic logic [5:0] vdec(input logic [7:0] lo8);
    case (lo8)
      8'hc9: vdec = {1'b1, 3'd0, 2'd0};
      8'hca: vdec = {1'b1, 3'd0, 2'd1};
      8'hd8: vdec = {1'b1, 3'd1, 2'd0};
      8'hec: vdec = {1'b1, 3'd2, 2'd0};
      8'hee: vdec = {1'b1, 3'd3, 2'd0};
      8'hef: vdec = {1'b1, 3'd3, 2'd1};
      8'hf4: vdec = {1'b1, 3'd4, 2'd0};
      8'hf5: vdec = {1'b1, 3'd4, 2'd1};
      8'hf6: vdec = {1'b1, 3'd4, 2'd2};
      8'hf8: vdec = {1'b1, 3'd5, 2'd0};
      8'hf9: vdec = {1'b1, 3'd5, 2'd1};
      8'hfa: vdec = {1'b1, 3'd5, 2'd2};
      8'hfb: vdec = {1'b1, 3'd5, 2'd3};
      default: vdec = 6'h00;
    endcase
  endfunction

  // writable bits of each register
  function automatic logic [31:0] rmask(input logic [2:0] i);
    case (i)
      3'd0: rmask = `CVB_MSK_JACK;
      3'd1: rmask = `CVB_MSK_SLP;
      3'd2: rmask = `CVB_MSK_PORT;
      3'd3: rmask = `CVB_MSK_BEEP;
      3'd4: rmask = `CVB_MSK_BTL;
      default: rmask = `CVB_MSK_CAP;
    endcase
  endfunction

  // power-on contents, shared by reset and function reset
  function automatic logic [5:0][31:0] rdef();
    rdef = '0;
    rdef[0] = `CVB_DEF_JACK;
    rdef[3] = `CVB_DEF_BEEP;
    rdef[4] = `CVB_DEF_BTL;
    rdef[5] = `CVB_DEF_CAP;
  endfunction

  // bias output delay in 0.1 ms units
  function automatic logic [15:0] bias_tab(input logic [2:0] c);
    case (c)
      3'd0: bias_tab = 16'd1;
      3'd1: bias_tab = 16'd500;
      3'd2: bias_tab = 16'd1250;
      3'd3: bias_tab = 16'd2500;
      3'd4: bias_tab = 16'd5000;
      3'd5: bias_tab = 16'd10000;
      3'd6: bias_tab = 16'd20000;
      default: bias_tab = 16'd40000;
    endcase
  endfunction

  // jack stable time in 0.1 ms units, saturating from code 12
  function automatic logic [13:0] stab(input logic [3:0] c);
    if (c == 4'd0) begin
      stab = 14'd1;
    end else if (c == 4'd1) begin
      stab = 14'd5;
    end else if (c >= 4'd12) begin
      stab = `CVB_STAB_MAX;
    end else begin
      stab = 14'd10 << (c - 4'd2);
    end
  endfunction

  assign raw = {pump_short_i, reg_short_i, temp_low_i, temp_high_i,
                beep_present_i, link_rst_n_i};
  assign hi = st.flt[`CVB_I_HI];
  assign lo = st.flt[`CVB_I_LO];
  assign vd = vdec(verb_id_i[7:0]);
  assign m = rmask(vd[4:2]);
  assign ms_tick = (st.tick == 16'(MS_CYCLES - 1));
  assign step = ms_tick && ((st.ms + 17'd1) >= st.wait_ms);
  // link reset released: filtered level goes low to high
  assign lrst_rise = !st.flt[`CVB_I_LRST] &&
                     (st.s2[`CVB_I_LRST] == st.s3[`CVB_I_LRST]) &&
                     st.s3[`CVB_I_LRST];
  // thermal status word
  assign stat = {12'h000, hi, lo, st.mute, st.off, st.vol, st.vol};

  // whole next state
  always_comb begin
    next_st = st;
    nv = st.regs[vd[4:2]];
    nv[{vd[1:0], 3'b000} +: 8] = verb_payload_i;
    // three-stage synchroniser, change taken when stages two and three agree
    next_st.s1 = raw;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    for (int i = 0; i < 6; i++) begin
      if (st.s2[i] == st.s3[i]) begin
        next_st.flt[i] = st.s3[i];
      end
    end
    // verb handling; a sleeping link answers nothing
    next_st.resp_valid = 1'b0;
    next_st.frst_pend = 1'b0; // one cycle only; the reset it applies wins over a write in that cycle
    if (verb_valid_i && st.sleep == CVB_RUN) begin
      next_st.resp_valid = 1'b1;
      next_st.resp_data = '0;
      if (verb_id_i[11:8] == `CVB_SET) begin
        if (vd[5]) begin
          next_st.regs[vd[4:2]] = (nv & m) | (st.regs[vd[4:2]] & ~m);
        end
        if (verb_id_i[7:0] == `CVB_V_RST && verb_payload_i == `CVB_FRST_KEY) begin
          next_st.frst_pend = 1'b1;
        end
      end else if (verb_id_i[11:8] == `CVB_GET) begin
        if (verb_id_i[7:0] == `CVB_V_STAT) begin
          next_st.resp_data = stat;
        end else if (vd[5]) begin
          next_st.resp_data = st.regs[vd[4:2]];
          if (vd[4:2] == 3'd3) begin
            next_st.resp_data[`CVB_B_BSTAT] = st.beep_stat;
          end
          if (vd[4:2] == 3'd5) begin
            next_st.resp_data[`CVB_B_RFLAG] = st.regs[5][`CVB_B_RSEN] &
                                              st.flt[`CVB_I_RSC];
            next_st.resp_data[`CVB_B_PFLAG] = st.regs[5][`CVB_B_PSEN] &
                                              st.flt[`CVB_I_PSC];
          end
        end
      end
    end
    // function reset lands the cycle after its answer and wins over writes
    if (st.frst_pend) begin
      next_st.regs = rdef();
    end
    // beep presence, cleared by function or link reset
    next_st.beep_stat = st.flt[`CVB_I_BEEP] && !st.frst_pend &&
                        st.flt[`CVB_I_LRST];
    // vendor sleep states
    case (st.sleep)
      CVB_RUN: begin
        if (d3cold_i && st.regs[1][`CVB_B_DEEP]) begin
          next_st.sleep = CVB_DEEP;
        end else if (d3cold_i && st.regs[1][`CVB_B_LIGHT]) begin
          next_st.sleep = CVB_LIGHT;
        end
      end
      CVB_LIGHT, CVB_DEEP: begin
        if (lrst_rise) begin
          next_st.sleep = CVB_RUN;
        end
      end
      default: next_st.sleep = CVB_RUN;
    endcase
    // millisecond time base for the thermal ramp
    next_st.tick = ms_tick ? 16'h0000 : st.tick + 16'h0001;
    if (st.regs[4][`CVB_B_SINGLE]) begin
      next_st.vol = hi ? 8'h00 : 8'hff;
      next_st.ms = '0;
    end else if (ms_tick) begin
      next_st.ms = step ? 17'h00000 : st.ms + 17'h00001;
      if (step && hi && st.vol != 8'h00) begin
        next_st.vol = st.vol - 8'h01;
      end else if (step && !hi && !lo && st.vol != 8'hff) begin
        next_st.vol = st.vol + 8'h01;
      end
    end
    // forced silence and power-down while still hot at zero volume
    if (st.regs[4][`CVB_B_FORCE] && hi && st.vol == 8'h00) begin
      next_st.mute = 1'b1;
      next_st.off = 1'b1;
    end else if (!hi || !st.regs[4][`CVB_B_FORCE]) begin
      next_st.mute = 1'b0;
      next_st.off = 1'b0;
    end
    // decoded controls, registered so outputs leave flip-flops
    next_st.link_off = st.sleep != CVB_RUN;
    next_st.pins_off = st.sleep == CVB_DEEP;
    next_st.port_off = st.regs[2][3:0];
    next_st.stable = st.regs[0][`CVB_B_BYP] ? `CVB_TEST_DLY :
                     stab(st.regs[0][11:8]);
    next_st.bias = st.regs[0][`CVB_B_BYP] ? 16'(`CVB_TEST_DLY) :
                   bias_tab(st.regs[0][2:0]);
    next_st.mic_frames = 9'd2 << st.regs[0][14:12];
    next_st.long_s = (st.regs[0][6:4] == 3'd7) ? 8'h00 :
                     8'd2 << st.regs[0][6:4];
    next_st.beep_gain = {4'h0, st.regs[3][12:10]} * `CVB_GSTEP - `CVB_GMIN;
    next_st.beep_ms = 10'd64 << st.regs[3][3:2];
    next_st.beep_quant = st.regs[3][`CVB_B_QEN] & st.regs[3][`CVB_B_DEN];
    next_st.beep_on = st.regs[3][1] ? !st.flt[`CVB_I_LRST] : st.regs[3][0];
    next_st.wait_ms = 17'd2 << {1'b0, st.regs[4][11:9]};
    next_st.poll_ms = (st.wait_ms >= `CVB_POLL_MAX) ? 5'd16 : st.wait_ms[4:0];
    next_st.low_trip = `CVB_TRIP_MIN + `CVB_TRIP_STEP * {5'h00, st.regs[4][7:5]};
    next_st.pump_div = st.regs[5][11] ?
                       `CVB_DIV_MID - {2'b00, st.regs[5][10:8], 1'b0} :
                       `CVB_DIV_MID + {2'b00, st.regs[5][10:8], 1'b0};
    next_st.pump_sel = st.regs[5][`CVB_B_PSEL];
    next_st.reg_sense = st.regs[5][`CVB_B_RSEN];
    next_st.pump_sense = st.regs[5][`CVB_B_PSEN];
  end

  // state register; decoded fields settle one cycle after reset
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      // link reset stages start at the pin's idle high, so no false release follows
      st <= '{regs: {`CVB_DEF_CAP, `CVB_DEF_BTL, `CVB_DEF_BEEP, 32'h0000_0000,
                     32'h0000_0000, `CVB_DEF_JACK},
              s1: 6'h01, s2: 6'h01, s3: 6'h01, flt: 6'h01,
              vol: 8'hff, wait_ms: 17'd16, sleep: CVB_RUN, default: '0};
    end else begin
      st <= next_st;
    end
  end

  assign resp_valid_o    = st.resp_valid;
  assign resp_data_o     = st.resp_data;
  assign link_if_off_o   = st.link_off;
  assign pins_amps_off_o = st.pins_off;
  assign port_off_o      = st.port_off;
  assign jack_stable_o   = st.stable;
  assign mic_frames_o    = st.mic_frames;
  assign long_detect_o   = st.long_s;
  assign bias_delay_o    = st.bias;
  assign beep_gain_o     = st.beep_gain;
  assign beep_delay_o    = st.beep_ms;
  assign beep_quant_o    = st.beep_quant;
  assign beep_path_on_o  = st.beep_on;
  assign step_wait_o     = st.wait_ms;
  assign poll_ms_o       = st.poll_ms;
  assign low_trip_o      = st.low_trip;
  assign spk_vol_o       = st.vol;
  assign spk_mute_o      = st.mute;
  assign spk_off_o       = st.off;
  assign pump_div_o      = st.pump_div;
  assign pump_sel_o      = st.pump_sel;
  assign reg_sense_en_o  = st.reg_sense;
  assign pump_sense_en_o = st.pump_sense;

  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_frst;
    verb_valid_i && verb_id_i == {`CVB_SET, `CVB_V_RST} &&
    verb_payload_i == `CVB_FRST_KEY && st.sleep == CVB_RUN;
  endsequence
  sequence s_ack_then_clear;
    resp_valid_o ##1 (st.regs[3] == `CVB_DEF_BEEP && st.regs[2] == 32'h0);
  endsequence

  AST_FRST: assert property (s_frst |=> s_ack_then_clear)
    else $error("function reset not acknowledged then applied");
  AST_QUIET: assert property (verb_valid_i && st.sleep != CVB_RUN |=> !resp_valid_o)
    else $error("response sent while asleep");
  AST_DEEP: assert property (st.sleep == CVB_RUN && d3cold_i && st.regs[1][1]
                             |=> st.sleep == CVB_DEEP ##1 pins_amps_off_o)
    else $error("deepest sleep not entered");
  AST_STAY: assert property (st.sleep != CVB_RUN && !lrst_rise |=> $stable(st.sleep))
    else $error("sleep left without link reset release");
  AST_QUANT: assert property (1'b1 |=> beep_quant_o == $past(st.regs[3][9] & st.regs[3][8]))
    else $error("quantize enable wrong");
  AST_BYP: assert property (st.regs[0][15] |=> jack_stable_o == 14'd1)
    else $error("debounce bypass ignored");
  AST_SINGLE: assert property (st.regs[4][16] && hi |=> spk_vol_o == 8'h00)
    else $error("single trip did not cut volume");
  AST_FORCE: assert property (st.regs[4][17] && hi && spk_vol_o == 8'h00
                              |=> spk_off_o && spk_mute_o)
    else $error("forced power-down missing");
  AST_PUMP: assert property (st.regs[5][11:8] == 4'hf |=> pump_div_o == 6'd16)
    else $error("pump divisor wrong");
  AST_TRIP: assert property (st.regs[4][7:5] == 3'd7 |=> low_trip_o == 8'd215)
    else $error("low trip wrong");

  sequence s_light_in;
    st.sleep == CVB_LIGHT ##1 (link_if_off_o && !pins_amps_off_o);
  endsequence
  sequence s_awake;
    st.sleep == CVB_RUN ##1 !link_if_off_o;
  endsequence

  AST_LIGHT: assert property (st.sleep == CVB_RUN && d3cold_i && st.regs[1][1:0] == 2'b01
                              |=> s_light_in)
    else $error("lighter sleep not entered");
  AST_WAKE: assert property (st.sleep != CVB_RUN && lrst_rise |=> s_awake)
    else $error("link reset release did not wake");
  AST_BPATH: assert property (st.regs[3][1] && !st.flt[`CVB_I_LRST] |=> beep_path_on_o)
    else $error("beep path off during link reset");
  AST_BSTAT: assert property (!st.flt[`CVB_I_LRST] |=> !st.beep_stat)
    else $error("beep status kept during link reset");
  AST_POLL: assert property (step_wait_o >= 17'd16 |=> poll_ms_o == 5'd16)
    else $error("polling not capped");
  AST_RAMP: assert property (!st.regs[4][16] && step && hi && spk_vol_o != 8'h00
                             |=> spk_vol_o == $past(spk_vol_o) - 8'h01)
    else $error("volume did not step down");

endmodule
`default_nettype wire

// >>> sim/cvb_host.sv
// host link model: verbs, link reset and the cold power command
`timescale 1ns/1ps
`default_nettype none
module cvb_host (
  input  wire logic        clk_i,
  input  wire logic        resp_valid_i,
  input  wire logic [31:0] resp_data_i,
  output logic             verb_valid_o,
  output logic [11:0]      verb_id_o,
  output logic [7:0]       verb_payload_o,
  output logic             link_rst_n_o,
  output logic             d3cold_o
);
  // idle levels at time zero
  initial begin
    verb_valid_o = 1'b0;
    verb_id_o = 12'h000;
    verb_payload_o = 8'h00;
    link_rst_n_o = 1'b1;
    d3cold_o = 1'b0;
  end
  // one verb per call; idle lines carry the inverse so stale data never matches
  task automatic send(input logic [11:0] id, input logic [7:0] pl,
                      output logic got, output logic [31:0] data);
    @(negedge clk_i);
    verb_valid_o = 1'b1;
    verb_id_o = id;
    verb_payload_o = pl;
    // the answer pulse stands for the one cycle after the verb edge
    @(negedge clk_i);
    got = resp_valid_i;
    data = resp_data_i;
    verb_valid_o = 1'b0;
    verb_id_o = ~id;
    verb_payload_o = ~pl;
  endtask
  // a low pulse then release is the only wake-up from vendor sleep besides power-on reset
  task automatic link_set(input logic v);
    @(negedge clk_i);
    link_rst_n_o = v;
  endtask
  // caller sets the sleep bits before raising this
  task automatic cold(input logic v);
    @(negedge clk_i);
    d3cold_o = v;
  endtask
endmodule
`default_nettype wire

// >>> sim/tb_codec_vendor_control_bank.sv
// self-checking bench of the vendor control bank
`timescale 1ns/1ps
`default_nettype none
`include "cvb_map.svh"
module tb_codec_vendor_control_bank;
  localparam int MS = 10;
  localparam logic [31:0] MSK [6] = '{`CVB_MSK_JACK, `CVB_MSK_SLP, `CVB_MSK_PORT,
    `CVB_MSK_BEEP, `CVB_MSK_BTL, `CVB_MSK_CAP};
  localparam logic [31:0] DEF [6] = '{`CVB_DEF_JACK, 32'h0, 32'h0, `CVB_DEF_BEEP,
    `CVB_DEF_BTL, `CVB_DEF_CAP};
  localparam logic [7:0] GID [6] = '{8'hc9, 8'hd8, 8'hec, 8'hee, 8'hf4, 8'hf8};
  localparam logic [7:0] LID [13] = '{8'hc9, 8'hca, 8'hd8, 8'hec, 8'hee, 8'hef, 8'hf4,
    8'hf5, 8'hf6, 8'hf8, 8'hf9, 8'hfa, 8'hfb};
  localparam int LRG [13] = '{0, 0, 1, 2, 3, 3, 4, 4, 4, 5, 5, 5, 5};
  localparam int LBY [13] = '{0, 1, 0, 0, 0, 1, 0, 1, 2, 0, 1, 2, 3};
  localparam int BIAS [8] = '{1, 500, 1250, 2500, 5000, 10000, 20000, 40000};
  logic        clk, rst_n, link_rst_n, vv, cold, bp, th, tl, rs, ps, rv;
  logic        lif, pao, bq, bpo, sm, so, psel, rse, pse;
  logic [11:0] vid;
  logic [7:0]  vpl, lng, ltr, vol;
  logic [31:0] rd, rnd;
  logic [3:0]  po;
  logic [13:0] stb;
  logic [8:0]  mic;
  logic [15:0] bias;
  logic [6:0]  gain;
  logic [9:0]  bdly;
  logic [16:0] wt;
  logic [4:0]  poll;
  logic [5:0]  div;
  logic [31:0] mdl [6];
  logic        bst;
  int          n_mismatch, cmp_count;

  cvb_bank #(.MS_CYCLES(MS)) cvb_bank_i (.clk_i(clk), .rst_n_i(rst_n),
    .link_rst_n_i(link_rst_n), .verb_valid_i(vv), .verb_id_i(vid), .verb_payload_i(vpl),
    .d3cold_i(cold), .beep_present_i(bp), .temp_high_i(th), .temp_low_i(tl),
    .reg_short_i(rs), .pump_short_i(ps), .resp_valid_o(rv), .resp_data_o(rd),
    .link_if_off_o(lif), .pins_amps_off_o(pao), .port_off_o(po), .jack_stable_o(stb),
    .mic_frames_o(mic), .long_detect_o(lng), .bias_delay_o(bias), .beep_gain_o(gain),
    .beep_delay_o(bdly), .beep_quant_o(bq), .beep_path_on_o(bpo), .step_wait_o(wt),
    .poll_ms_o(poll), .low_trip_o(ltr), .spk_vol_o(vol), .spk_mute_o(sm), .spk_off_o(so),
    .pump_div_o(div), .pump_sel_o(psel), .reg_sense_en_o(rse), .pump_sense_en_o(pse));
  cvb_host cvb_host_i (.clk_i(clk), .resp_valid_i(rv), .resp_data_i(rd), .verb_valid_o(vv),
    .verb_id_o(vid), .verb_payload_o(vpl), .link_rst_n_o(link_rst_n), .d3cold_o(cold));

  // 50 MHz clock
  always #10 clk = ~clk;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // live bits are merged on read, stored words keep only writable bits
  function automatic logic [31:0] exp_get(input int i);
    logic [31:0] v;
    v = mdl[i];
    if (i == 3) v[13] = bst;
    if (i == 5) v[25:24] = {v[19] & rs, v[16] & ps};
    return v;
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // one byte lane write, model follows with reserved bits dropped
  task automatic wr(input int k, input logic [7:0] pl);
    logic        g;
    logic [31:0] d;
    cvb_host_i.send({4'h7, LID[k]}, pl, g, d);
    chk("set ack", {31'h0, g}, 32'h1);
    mdl[LRG[k]][8*LBY[k] +: 8] = pl;
    mdl[LRG[k]] &= MSK[LRG[k]];
  endtask
  // decoded settings against the model words
  task automatic chk_dec();
    logic [31:0] j, b, t, c;
    int          s, w;
    j = mdl[0];
    b = mdl[3];
    t = mdl[4];
    c = mdl[5];
    s = int'(j[11:8]);
    w = 2 << t[11:9];
    chk("port off", 32'(po), 32'(mdl[2][3:0]));
    chk("stable", 32'(stb), j[15] ? 1 : s == 0 ? 1 : s == 1 ? 5 : s > 11 ? 10240 :
      10 << (s - 2));
    chk("mic frames", 32'(mic), 2 << j[14:12]);
    chk("long detect", 32'(lng), j[6:4] == 3'h7 ? 0 : 2 << j[6:4]);
    chk("bias", 32'(bias), j[15] ? 1 : BIAS[j[2:0]]);
    chk("beep gain", 32'(gain), 32'(7'(6 * b[12:10] - 48)));
    chk("beep delay", 32'(bdly), 64 << b[3:2]);
    chk("quantize", 32'(bq), 32'(b[9] & b[8]));
    chk("beep path", 32'(bpo), 32'(b[1:0] == 2'b01 || (b[1] && !link_rst_n)));
    chk("step wait", 32'(wt), w);
    chk("poll", 32'(poll), w > 16 ? 16 : w);
    chk("low trip", 32'(ltr), 110 + 15 * t[7:5]);
    chk("pump div", 32'(div), c[11] ? 46 - 2 * c[11:8] : 30 + 2 * c[11:8]);
    chk("pump source", 32'(psel), 32'(c[4]));
    chk("reg sense", 32'(rse), 32'(c[19]));
    chk("pump sense", 32'(pse), 32'(c[16]));
  endtask
  // read back every word, idle thermal status and the decodes
  task automatic t_regs(input string nm);
    logic        g;
    logic [31:0] d;
    for (int i = 0; i < 6; i++) begin
      cvb_host_i.send({4'hf, GID[i]}, 8'h00, g, d);
      chk("get ack", {31'h0, g}, 32'h1);
      chk(nm, d, exp_get(i));
    end
    cvb_host_i.send(12'hff7, 8'h00, g, d);
    chk("idle status", d, {13'h0, tl, 18'h0_ffff});
    chk_dec();
    $display("test %s done", nm);
  endtask
  // volume settle with a bounded wait
  task automatic wait_vol(input logic [7:0] v);
    int n;
    n = 0;
    while (vol !== v && n < 1000) begin
      @(negedge clk);
      n++;
    end
    if (n == 1000) begin
      chk("volume wait", 32'(vol), 32'(v));
      complete_run();
    end
  endtask

  // main sequence
  initial begin
    logic        g;
    logic [31:0] d;
    clk = 1'b0;
    rst_n = 1'b0;
    {bp, th, tl, rs, ps, bst} = 6'h00;
    rnd = 32'hda99ce47;
    n_mismatch = 0;
    cmp_count = 0;
    repeat (10) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    foreach (mdl[i]) mdl[i] = DEF[i];
    t_regs("reset values");
    // random lanes and random live inputs
    repeat (4) begin
      repeat (10) begin
        rnd = lfsr(rnd);
        wr(int'(rnd[15:8]) % 13, rnd[7:0]);
        {bp, rs, ps, tl} = rnd[19:16];
        bst = bp;
      end
      t_regs("random lanes");
    end
    // unmapped places answer zero and change nothing
    cvb_host_i.send(12'h7c0, 8'h5a, g, d);
    cvb_host_i.send(12'hfc0, 8'h00, g, d);
    chk("unmapped get", d, 32'h0);
    cvb_host_i.send(12'h7ff, 8'h01, g, d);
    t_regs("wrong reset key");
    cvb_host_i.send(12'h7ff, 8'h00, g, d);
    chk("reset ack", {31'h0, g}, 32'h1);
    foreach (mdl[i]) mdl[i] = DEF[i];
    t_regs("function reset");
    // every beep mode inside and outside link reset
    for (int m = 0; m < 4; m++) begin
      wr(4, {mdl[3][7:2], 2'(m)});
      cvb_host_i.link_set(1'b0);
      repeat (6) @(negedge clk);
      chk("path in link reset", 32'(bpo), 32'(m != 0));
      cvb_host_i.link_set(1'b1);
      repeat (6) @(negedge clk);
      chk("path out of reset", 32'(bpo), 32'(m == 1));
    end
    $display("test beep modes done");
    // deepest then lighter vendor sleep, woken by link reset release
    for (int k = 0; k < 2; k++) begin
      wr(2, k == 0 ? 8'h03 : 8'h01);
      cvb_host_i.cold(1'b1);
      repeat (3) @(negedge clk);
      chk("iface off", 32'(lif), 32'h1);
      chk("pins off", 32'(pao), 32'(k == 0));
      cvb_host_i.send(12'hfd8, 8'h00, g, d);
      chk("no answer asleep", {31'h0, g}, 32'h0);
      cvb_host_i.cold(1'b0);
      repeat (8) @(negedge clk);
      chk("stays asleep", 32'(lif), 32'h1);
      cvb_host_i.link_set(1'b0);
      repeat (4) @(negedge clk);
      cvb_host_i.link_set(1'b1);
      repeat (8) @(negedge clk);
      chk("iface back", 32'(lif), 32'h0);
      chk("pins back", 32'(pao), 32'h0);
    end
    wr(2, 8'h00);
    t_regs("vendor sleep");
    // short detectors for every enable pair
    rs = 1'b1;
    ps = 1'b1;
    wr(10, 8'h1f);
    for (int e = 0; e < 4; e++) begin
      wr(11, {4'h5, e[1], 2'b00, e[0]});
      t_regs("short sense");
    end
    // single trip cut, without then with forced power-down
    for (int f = 0; f < 2; f++) begin
      wr(8, {6'h00, 1'(f), 1'b1});
      {th, tl} = 2'b10;
      wait_vol(8'h00);
      // two and a half polling periods at the 16 ms cap
      repeat (40 * MS) @(negedge clk);
      chk("forced off", 32'(so), 32'(f));
      chk("forced mute", 32'(sm), 32'(f));
      cvb_host_i.send(12'hff7, 8'h00, g, d);
      chk("thermal status", d, {12'h0, 2'b10, 1'(f), 1'(f), 16'h0});
      th = 1'b0;
      wait_vol(8'hff);
    end
    $display("test thermal cut done");
    // smooth ramp: 2 ms steps down while hot, hold between trips, up when cool
    wr(7, 8'h00);
    wr(8, 8'h00);
    th = 1'b1;
    wait_vol(8'hfe);
    {th, tl} = 2'b01;
    repeat (10 * MS) @(negedge clk);
    chk("hold between trips", 32'(vol), 32'hfe);
    tl = 1'b0;
    wait_vol(8'hff);
    $display("test smooth ramp done");
    // power-on reset in mid-run
    rst_n = 1'b0;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    {bp, rs, ps, bst} = 4'h0;
    foreach (mdl[i]) mdl[i] = DEF[i];
    t_regs("second reset");
    complete_run();
  end
endmodule
`default_nettype wire
